// ---- verilog/fsp_ctrl.sv ----
// Flash self-program section control with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl
  import fsp_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic [1:0] i_boot_size_fuses,
  input wire logic i_chip_erase,
  input wire logic i_spm_req,
  input wire logic [11:0] i_spm_pc,
  input wire logic [11:0] i_spm_target,
  input wire logic i_spm_lock_wr,
  input wire logic [3:0] i_spm_lock_val,
  input wire logic i_load_req,
  input wire logic [11:0] i_load_pc,
  input wire logic [11:0] i_load_target,
  output logic o_cpu_stall,
  output logic o_concurrent_region_busy_flag,
  output logic o_load_allowed,
  output logic o_flash_prog,
  output logic o_irq,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  typedef enum logic [1:0] {
    FSP_IDLE = 2'b00,
    FSP_PROG_CONC = 2'b01,
    FSP_PROG_HALT = 2'b10
  } fsp_state_t;

  typedef struct packed {
    fsp_state_t st;
    logic [15:0] cnt;
    logic busy;
    logic [3:0] lock;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic stall;
    logic load_ok;
    logic irq;
    logic prog;
    logic aw_hold;
    logic [7:0] awaddr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fsp_regs_t;

  fsp_regs_t r;
  fsp_regs_t next_r;
  fsp_region_if spm_if();
  fsp_region_if ld_if();

  // ------------------------------------------------------------
  // Section decode
  // ------------------------------------------------------------
  assign spm_if.target = i_spm_target;
  assign spm_if.pc = i_spm_pc;
  assign spm_if.boot_size_fuses = i_boot_size_fuses;
  assign spm_if.application_lock_group = r.lock[1:0];
  assign spm_if.loader_lock_group = r.lock[3:2];
  assign ld_if.target = i_load_target;
  assign ld_if.pc = i_load_pc;
  assign ld_if.boot_size_fuses = i_boot_size_fuses;
  assign ld_if.application_lock_group = r.lock[1:0];
  assign ld_if.loader_lock_group = r.lock[3:2];

  fsp_region_decode u_spm_dec (.rif(spm_if.decoder));
  fsp_region_decode u_ld_dec (.rif(ld_if.decoder));

  logic [15:0] prog_last;
  assign prog_last = 16'(PROG_CYC - 1);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic spm_go;
    logic spm_bad;
    logic aw_ok;
    logic w_ok;
    logic do_wr;
    logic [31:0] wd;
    logic done;
    spm_go = 1'b0;
    spm_bad = 1'b0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    do_wr = 1'b0;
    wd = BUS_ZERO;
    done = 1'b0;
    next_r = r;

    // Programming only from boot code, any target, lock permitting
    if (i_spm_req && r.st == FSP_IDLE && !i_spm_lock_wr) begin
      if (spm_if.pc_in_boot_loader_section && spm_if.write_allowed) begin
        spm_go = 1'b1;
      end else begin
        spm_bad = 1'b1;
      end
    end
    // Lock bits can only be programmed (1 to 0) from boot code
    if (i_spm_req && i_spm_lock_wr && r.st == FSP_IDLE &&
        spm_if.pc_in_boot_loader_section) begin
      next_r.lock = r.lock & i_spm_lock_val;
    end

    unique case (r.st)
      FSP_IDLE: begin
        if (spm_go) begin
          next_r.cnt = 16'h0000;
          // Boot section lies above the halting boundary
          if (spm_if.tgt_in_halting_region) begin
            next_r.st = FSP_PROG_HALT;
          end else begin
            next_r.st = FSP_PROG_CONC;
            next_r.busy = 1'b1;
          end
        end
      end
      FSP_PROG_CONC, FSP_PROG_HALT: begin
        if (r.cnt == prog_last) begin
          next_r.st = FSP_IDLE;
          done = 1'b1;
        end else begin
          next_r.cnt = r.cnt + 16'h0001;
        end
      end
      default: next_r.st = FSP_IDLE;
    endcase

    next_r.stall = (next_r.st == FSP_PROG_HALT);
    next_r.prog = (next_r.st != FSP_IDLE);
    // Loads: lock policy, plus concurrent region blocked while busy
    next_r.load_ok = i_load_req && ld_if.read_allowed &&
      !(next_r.busy && !ld_if.tgt_in_halting_region);

    // ---------------- AXI4-Lite write ----------------
    if (i_awvalid && !r.aw_hold) begin
      next_r.aw_hold = 1'b1;
      next_r.awaddr = i_awaddr;
    end
    if (i_wvalid && !r.w_hold) begin
      next_r.w_hold = 1'b1;
      next_r.wdata = i_wdata;
      next_r.wstrb = i_wstrb;
    end
    aw_ok = r.aw_hold;
    w_ok = r.w_hold;
    if (aw_ok && w_ok && !r.bvalid) begin
      do_wr = 1'b1;
      next_r.aw_hold = 1'b0;
      next_r.w_hold = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      wd = r.wstrb[0] ? r.wdata : BUS_ZERO;
      unique case (r.awaddr)
        REG_CTRL: begin
          // Clear only once the operation has finished
          if (wd[CTRL_BUSY_CLR] && r.st == FSP_IDLE && !spm_go) begin
            next_r.busy = 1'b0;
          end
        end
        REG_IRQ_STAT: next_r.irq_stat = r.irq_stat & ~wd[IRQ_W-1:0];
        REG_IRQ_MASK: next_r.irq_mask = wd[IRQ_W-1:0];
        REG_STATUS, REG_LOCK: ;
        default: next_r.bresp = RESP_SLVERR;
      endcase
    end
    if (r.bvalid && i_bready) begin
      next_r.bvalid = 1'b0;
    end

    // Events win over a same-cycle clear
    if (done) begin
      next_r.irq_stat[IRQ_DONE] = 1'b1;
    end
    if (spm_bad) begin
      next_r.irq_stat[IRQ_REFUSED] = 1'b1;
    end
    if (i_chip_erase) begin
      next_r.lock = LOCK_RESET;
    end
    next_r.irq = |(next_r.irq_stat & next_r.irq_mask);

    // ---------------- AXI4-Lite read ----------------
    if (r.rvalid && i_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (i_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = BUS_ZERO;
      unique case (i_araddr)
        REG_CTRL: next_r.rdata = {29'h0000_0000, i_boot_size_fuses, 1'b0};
        REG_STATUS: next_r.rdata = {29'h0000_0000, r.st != FSP_IDLE,
          r.stall, r.busy};
        REG_IRQ_STAT: next_r.rdata = {30'h0000_0000, r.irq_stat};
        REG_IRQ_MASK: next_r.rdata = {30'h0000_0000, r.irq_mask};
        REG_LOCK: next_r.rdata = {28'h000_0000, r.lock};
        default: next_r.rresp = RESP_SLVERR;
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
      r.lock <= LOCK_RESET;
      r.st <= FSP_IDLE;
    end else if (i_clk_en) begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_cpu_stall = r.stall;
  assign o_concurrent_region_busy_flag = r.busy;
  assign o_load_allowed = r.load_ok;
  assign o_flash_prog = r.prog;
  assign o_irq = r.irq;
  assign o_awready = !r.aw_hold;
  assign o_wready = !r.w_hold;
  assign o_bvalid = r.bvalid;
  assign o_bresp = r.bresp;
  assign o_arready = !r.rvalid;
  assign o_rvalid = r.rvalid;
  assign o_rdata = r.rdata;
  assign o_rresp = r.rresp;
endmodule // fsp_ctrl
`default_nettype wire

// ---- verilog/fsp_pkg.sv ----
// Package of constants for the flash self-program section control
package fsp_pkg;
  // Flash geometry (word addresses, 4K words)
  localparam int ADDR_W = 12;
  localparam logic [11:0] HALT_REGION_BASE = 12'hC00;
  // Boot section start per boot_size_fuses code
  localparam logic [11:0] BOOT_BASE_00 = 12'hC00;
  localparam logic [11:0] BOOT_BASE_01 = 12'hE00;
  localparam logic [11:0] BOOT_BASE_10 = 12'hF00;
  localparam logic [11:0] BOOT_BASE_11 = 12'hF80;
  // Programming time
  localparam int PROG_TIME_US = 4500;
  localparam int CLK_MHZ = 10;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_LOCK = 8'h10;
  // CTRL fields
  localparam int CTRL_BUSY_CLR = 0;
  localparam int CTRL_BOOT_SZ_LO = 1;
  // STATUS fields
  localparam int ST_BUSY = 0;
  localparam int ST_HALT = 1;
  localparam int ST_ACTIVE = 2;
  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_W = 2;
  // Lock register fields: [1:0] application group, [3:2] loader group
  localparam logic [3:0] LOCK_RESET = 4'h_F;
  localparam logic [1:0] LOCK_NONE = 2'b11;
  localparam logic [1:0] LOCK_NO_WR = 2'b10;
  localparam logic [1:0] LOCK_ALL = 2'b00;
  localparam logic [1:0] LOCK_NO_RD = 2'b01;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- verilog/fsp_region_if.sv ----
// Interface carrying a decoded target and region classification
`timescale 1ns/1ps
`default_nettype none
interface fsp_region_if;
  import fsp_pkg::*;
  logic [11:0] target;
  logic [11:0] pc;
  logic [1:0] boot_size_fuses;
  logic [1:0] application_lock_group;
  logic [1:0] loader_lock_group;
  logic tgt_in_halting_region;
  logic pc_in_boot_loader_section;
  logic tgt_in_boot_loader_section;
  logic write_allowed;
  logic read_allowed;
  modport requester (output target, pc, boot_size_fuses,
    application_lock_group, loader_lock_group,
    input tgt_in_halting_region, pc_in_boot_loader_section,
    tgt_in_boot_loader_section, write_allowed, read_allowed);
  modport decoder (input target, pc, boot_size_fuses,
    application_lock_group, loader_lock_group,
    output tgt_in_halting_region, pc_in_boot_loader_section,
    tgt_in_boot_loader_section, write_allowed, read_allowed);
endinterface
`default_nettype wire

// ---- verilog/fsp_region_decode.sv ----
// Section and region decoder with lock-group policy
`timescale 1ns/1ps
`default_nettype none
module fsp_region_decode
  import fsp_pkg::*;
(
  fsp_region_if.decoder rif
);
  logic [11:0] boot_base;
  logic [1:0] tgt_lock;
  always_comb begin
    unique case (rif.boot_size_fuses)
      2'b00: boot_base = BOOT_BASE_00;
      2'b01: boot_base = BOOT_BASE_01;
      2'b10: boot_base = BOOT_BASE_10;
      2'b11: boot_base = BOOT_BASE_11;
    endcase
  end
  // Boot section never starts below the halting region base
  assign rif.tgt_in_halting_region = rif.target >= HALT_REGION_BASE;
  assign rif.pc_in_boot_loader_section = rif.pc >= boot_base;
  assign rif.tgt_in_boot_loader_section = rif.target >= boot_base;
  assign tgt_lock = rif.tgt_in_boot_loader_section ?
    rif.loader_lock_group : rif.application_lock_group;
  always_comb begin
    unique case (tgt_lock)
      LOCK_NONE: begin
        rif.write_allowed = 1'b1;
        rif.read_allowed = 1'b1;
      end
      LOCK_NO_WR: begin
        rif.write_allowed = 1'b0;
        rif.read_allowed = 1'b1;
      end
      LOCK_ALL: begin
        rif.write_allowed = 1'b0;
        rif.read_allowed = 1'b0;
      end
      LOCK_NO_RD: begin
        rif.write_allowed = 1'b1;
        rif.read_allowed = 1'b0;
      end
    endcase
    // Same-section loads are never blocked by the lock bits
    if (rif.pc_in_boot_loader_section == rif.tgt_in_boot_loader_section) begin
      rif.read_allowed = 1'b1;
    end
  end
endmodule // fsp_region_decode
`default_nettype wire

// ---- test/fsp_core_model.sv ----
// Processor core model that issues store-program and load requests
`timescale 1ns/1ps
`default_nettype none
module fsp_core_model (
  input wire logic i_core_clk,
  output logic o_spm_req,
  output logic [11:0] o_spm_pc,
  output logic [11:0] o_spm_target,
  output logic o_lock_wr,
  output logic [3:0] o_lock_val,
  output logic o_load_req,
  output logic [11:0] o_load_pc,
  output logic [11:0] o_load_target
);
  initial begin
    o_spm_req = 1'h0;
    o_spm_pc = 12'h0;
    o_spm_target = 12'h0;
    o_lock_wr = 1'h0;
    o_lock_val = 4'hF;
    o_load_req = 1'h0;
    o_load_pc = 12'h0;
    o_load_target = 12'h0;
  end
  // One store-program instruction; pc and target are inverted afterwards, lock value is left as is
  task automatic store_program_instruction(input logic [11:0] pc, input logic [11:0] t,
                     input logic lw, input logic [3:0] lv);
    @(posedge i_core_clk);
    o_spm_req <= 1'h1;
    o_spm_pc <= pc;
    o_spm_target <= t;
    o_lock_wr <= lw;
    o_lock_val <= lv;
    @(posedge i_core_clk);
    o_spm_req <= 1'h0;
    o_lock_wr <= 1'h0;
    o_spm_pc <= ~pc;
    o_spm_target <= ~t;
  endtask
  // Loads reach the busy region only when a scenario asks for it
  task automatic load(input logic [11:0] pc, input logic [11:0] t);
    @(posedge i_core_clk);
    o_load_req <= 1'h1;
    o_load_pc <= pc;
    o_load_target <= t;
    @(posedge i_core_clk);
    o_load_req <= 1'h0;
    o_load_target <= ~t;
  endtask
endmodule // fsp_core_model
`default_nettype wire

// ---- test/fsp_ctrl_props.sv ----
// Assertions on the ports of the flash self-program section control
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl_props
  import fsp_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic [1:0] i_boot_size_fuses,
  input wire logic i_spm_req,
  input wire logic [11:0] i_spm_pc,
  input wire logic [11:0] i_spm_target,
  input wire logic i_spm_lock_wr,
  input wire logic i_load_req,
  input wire logic [11:0] i_load_target,
  input wire logic o_cpu_stall,
  input wire logic o_concurrent_region_busy_flag,
  input wire logic o_load_allowed,
  input wire logic o_flash_prog,
  input wire logic o_awready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready
);
  localparam logic [11:0] BASE [4] = '{BOOT_BASE_00, BOOT_BASE_01,
    BOOT_BASE_10, BOOT_BASE_11};
  wire logic busy = o_concurrent_region_busy_flag;
  int n_stall;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // Length of the current stall in cycles
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      n_stall <= 0;
    end else begin
      // Only enabled edges advance the operation
      n_stall <= o_cpu_stall ? n_stall + int'(i_clk_en) : 0;
    end
  end
  // ---
  // Checks
  // ---
  sequence s_idle_req;
    i_spm_req && !o_flash_prog && !i_spm_lock_wr;
  endsequence
  sequence s_rd_hold;
    o_rvalid && $stable(o_rdata);
  endsequence
  chk_app_ignored: assert property (
    s_idle_req ##0 (i_spm_pc < BASE[i_boot_size_fuses]) |=> !o_flash_prog)
    else $error("store from application section started");
  chk_stall_select: assert property (
    $rose(o_flash_prog) |->
      o_cpu_stall == ($past(i_spm_target) >= HALT_REGION_BASE))
    else $error("stall does not follow target region");
  chk_stall_len: assert property (
    $fell(o_cpu_stall) |-> n_stall inside {[PROG_CYC:PROG_CYC+1]})
    else $error("stall length wrong");
  chk_low_no_stall: assert property (
    s_idle_req ##0 (i_spm_target < HALT_REGION_BASE) |=> !o_cpu_stall)
    else $error("concurrent region store stalled the core");
  chk_busy_rise: assert property (
    $rose(busy) |-> o_flash_prog && !o_cpu_stall)
    else $error("busy raised without a concurrent operation");
  chk_busy_held: assert property (
    $fell(busy) |-> !o_flash_prog && !($past(o_awready) && $past(o_awready, 2)))
    else $error("busy dropped without a clear write");
  chk_load_blocked: assert property (
    i_load_req && busy && i_load_target < HALT_REGION_BASE |=> !o_load_allowed)
    else $error("load of busy region allowed");
  chk_rd_hold: assert property (
    o_rvalid && !i_rready |=> s_rd_hold)
    else $error("read data not held");
  chk_wr_hold: assert property (
    o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response not held");
endmodule // fsp_ctrl_props
bind fsp_ctrl fsp_ctrl_props #(.PROG_CYC(PROG_CYC)) u_props (.*);
`default_nettype wire

// ---- test/flash_self_program_section_control_bench.sv ----
// Self-checking bench for the flash self-program section control
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_section_control_bench;
  import fsp_pkg::*;
  localparam logic [11:0] BASE [4] = '{BOOT_BASE_00, BOOT_BASE_01,
    BOOT_BASE_10, BOOT_BASE_11};
  logic i_core_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic i_chip_erase = 1'h0;
  logic i_clk_en = 1'h1;
  logic [1:0] i_boot_size_fuses = 2'h2;
  logic i_spm_req, i_spm_lock_wr, i_load_req, a, ta, tr, tw, tb;
  logic [11:0] i_spm_pc, i_spm_target, i_load_pc, i_load_target, t;
  logic [3:0] i_spm_lock_val;
  logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata, q;
  logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
  logic i_arvalid = 1'h0, i_rready = 1'h0;
  logic o_cpu_stall, o_concurrent_region_busy_flag, o_load_allowed;
  logic o_flash_prog, o_irq, o_awready, o_wready, o_bvalid;
  logic o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, r;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #50 i_core_clk = ~i_core_clk;
  fsp_ctrl #(.PROG_CYC(8)) uut (.*, .i_wstrb(4'hF));
  fsp_core_model core (.i_core_clk(i_core_clk), .o_spm_req(i_spm_req),
    .o_spm_pc(i_spm_pc), .o_spm_target(i_spm_target),
    .o_lock_wr(i_spm_lock_wr), .o_lock_val(i_spm_lock_val),
    .o_load_req(i_load_req), .o_load_pc(i_load_pc),
    .o_load_target(i_load_target));
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h", $time, m, got);
    end
  endtask
  // AXI4-Lite access; ready for the answer is raised late on purpose
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge i_core_clk);
    i_awaddr <= ad;
    i_araddr <= ad;
    i_wdata <= d;
    i_awvalid <= w;
    i_wvalid <= w;
    i_arvalid <= !w;
    for (int k = 0; k < 50; k++) begin
      #1;
      ta = i_awvalid && o_awready;
      tr = i_arvalid && o_arready;
      tw = i_wvalid && o_wready;
      tb = (i_bready && o_bvalid) || (i_rready && o_rvalid);
      q = o_rdata;
      r = w ? o_bresp : o_rresp;
      @(posedge i_core_clk);
      i_awvalid <= i_awvalid && !ta;
      i_arvalid <= i_arvalid && !tr;
      i_wvalid <= i_wvalid && !tw;
      if (k == 2) i_bready <= w;
      if (k == 2) i_rready <= !w;
      if (tb) begin
        i_bready <= 1'h0;
        i_rready <= 1'h0;
        #1;
        return;
      end
    end
    chk(32'h0, 32'h1, "bus timeout");
    give_verdict();
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 40 && o_flash_prog !== 1'h0; k++) @(posedge i_core_clk);
    #1 chk(o_flash_prog, 1'h0, "operation hung");
    if (o_flash_prog !== 1'h0) give_verdict();
  endtask
  task automatic erase();
    @(posedge i_core_clk) i_chip_erase <= 1'h1;
    @(posedge i_core_clk) i_chip_erase <= 1'h0;
  endtask
  // ---
  // Scenarios
  // ---
  initial begin
    void'($urandom(30116));
    repeat (2) @(posedge i_core_clk);
    i_reset_n <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      bus(1'h0, 8'(4 * i), 32'h0);
      chk(q, i == 0 ? 32'h4 : i == 4 ? 32'hF : 32'h0, "reset value");
      chk(r, i == 5 ? RESP_SLVERR : RESP_OKAY, "response");
    end
    for (int f = 0; f < 4; f++) begin
      i_boot_size_fuses <= 2'(f);
      core.store_program_instruction(BASE[f] - 12'h1, 12'hC00 | 12'($urandom), 1'h0, 4'hF);
      #1 chk(o_flash_prog, 1'h0, "application store ran");
      core.store_program_instruction(BASE[f] | 12'($urandom % 128), 12'hC00 | 12'($urandom), 1'h0, 4'hF);
      #1 chk({o_flash_prog, o_cpu_stall}, 2'h3, "halting store");
      wait_idle();
    end
    bus(1'h0, REG_IRQ_STAT, 32'h0);
    chk(q, 32'h3, "event status");
    a = o_irq;
    bus(1'h1, REG_IRQ_MASK, 32'h3);
    chk(a ^ o_irq, 1'h1, "mask has no effect");
    bus(1'h1, REG_IRQ_MASK, 32'h0);
    bus(1'h1, REG_IRQ_STAT, 32'h3);
    bus(1'h0, REG_IRQ_STAT, 32'h0);
    chk({q[1:0], o_irq}, 3'h0, "status not cleared");
    t = 12'($urandom % 3072);
    core.store_program_instruction(12'hFFF, t, 1'h0, 4'hF);
    #1 chk({o_cpu_stall, o_concurrent_region_busy_flag}, 2'h1, "low store");
    core.load(12'hFFF, 12'hC00 | t);
    #1 chk(o_load_allowed, 1'h1, "halting region blocked");
    core.load(12'hFFF, t);
    #1 chk(o_load_allowed, 1'h0, "busy region readable");
    wait_idle();
    bus(1'h0, REG_STATUS, 32'h0);
    chk(q, 32'h1, "busy not held");
    bus(1'h1, REG_CTRL, 32'h1);
    chk(o_concurrent_region_busy_flag, 1'h0, "busy not cleared");
    for (int c = 0; c < 4; c++) begin
      erase();
      core.store_program_instruction(12'hFFF, 12'h0, 1'h1, {2'h3, 2'(c)});
      core.load(12'hFFF, 12'h100);
      #1 chk(o_load_allowed, c[1], "cross-section load");
      core.store_program_instruction(12'hFFF, 12'h100, 1'h0, 4'hF);
      #1 chk(o_flash_prog, c[0], "application write lock");
      wait_idle();
      bus(1'h1, REG_CTRL, 32'h1);
    end
    core.store_program_instruction(12'hFFF, 12'h0, 1'h1, 4'h3);
    // Target inside the boot section, which starts at 0xF80 here
    core.store_program_instruction(12'hFFF, 12'hFC0, 1'h0, 4'hF);
    #1 chk(o_flash_prog, 1'h0, "loader lock ignored");
    bus(1'h1, REG_LOCK, 32'hF);
    bus(1'h0, REG_LOCK, 32'h0);
    chk(q, 32'h3, "lock released by write");
    erase();
    bus(1'h0, REG_LOCK, 32'h0);
    chk(q, 32'hF, "erase kept locks");
    // Clock enable low freezes a halting operation
    core.store_program_instruction(12'hFFF, 12'hC40, 1'h0, 4'hF);
    i_clk_en <= 1'h0;
    repeat (20) @(posedge i_core_clk);
    #1 chk({o_flash_prog, o_cpu_stall}, 2'h3, "clock enable ignored");
    @(posedge i_core_clk) i_clk_en <= 1'h1;
    wait_idle();
    give_verdict();
  end
endmodule // flash_self_program_section_control_bench
`default_nettype wire
